// ==== logic/bb_pkg.sv ====
// Constants, state codes and CRC helper for the 802.15.4 baseband.
// Assumes one 25 MHz core clock; software tables sit in system RAM.
package bb_pkg;
    // Clock and protocol times
    localparam int CLK_MHZ     = 25;
    localparam int BACKOFF_US  = 320;
    localparam int ACKWAIT_US  = 864;
    localparam int TURN_US     = 192;
    localparam int DIV_MS      = 60;
    localparam int BACKOFF_CYC = BACKOFF_US * CLK_MHZ;
    localparam int ACKWAIT_CYC = ACKWAIT_US * CLK_MHZ;
    localparam int TURN_CYC    = TURN_US * CLK_MHZ;
    localparam int DIV_CYC     = DIV_MS * 1000 * CLK_MHZ;
    // CSMA/CA limits
    localparam logic [2:0] MIN_BE = 3'h3;
    localparam logic [2:0] MAX_BE = 3'h5;
    localparam logic [2:0] MAX_NB = 3'h4;
    // Frame layout
    localparam logic [7:0]  HDR_LEN     = 8'h06;
    localparam logic [7:0]  ACK_HDR_LEN = 8'h04;
    localparam logic [7:0]  CRC_LEN     = 8'h02;
    localparam logic [7:0]  ACK_FC_LO   = 8'h02;
    localparam logic [2:0]  FC_ACK_TYPE = 3'h2;
    localparam int          FC_AR_BIT   = 5;
    localparam logic [1:0]  PRE_STOP    = 2'h2;
    localparam logic [15:0] CRC_POLY    = 16'h8408;
    localparam logic [15:0] LFSR_SEED   = 16'hACE1;
    // Supervisor states
    typedef enum logic [6:0] {
        S_IDLE = 7'h01, S_BO = 7'h02, S_CCA = 7'h04, S_TX = 7'h08,
        S_ACKW = 7'h10, S_RX = 7'h20, S_TURN = 7'h40
    } bb_st_type;
    // Reflected CRC-16 over one byte, low bit first
    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] x;
        x = c;
        for (int k = 0; k < 8; k++)
            x = (x[0] ^ d[k]) ? ((x >> 1) ^ CRC_POLY) : (x >> 1);
        return x;
    endfunction
endpackage

// ==== logic/bb_ieee802154_baseband.sv ====
// 802.15.4 baseband: scheduled CSMA/CA transmit, receive to RAM,
// auto acknowledge and antenna diversity control.
// Assumes RAM read data in the same cycle as the address; modem is byte wide.
`timescale 1ns/1ps
// Notes on behaviour
// - On timer hit the supervisor sequences transmit, payload fetched from RAM.
// - CSMA/CA with random backoffs and retries runs fully in hardware.
// - Header built from software parameters, sent ahead of payload to modem.
// - CRC computed while bytes flow and appended after the payload.
// - Received header and payload bytes are written to the RX buffer.
// - A pulse flags each completely received frame.
// - A separate pulse flags completion of an automatic acknowledgement.
// - Received CRC compared at frame end to judge integrity.
// - Modem link quality is latched when reception ends.
// - Frames asking for acknowledgement get one built and sent by hardware.
// - Hardware waits for and checks the acknowledgement of sent frames.
// - No ciphering; bytes pass between RAM and modem unaltered.
// - Transmit diversity swaps antenna for a retry after a missing ack.
// - Receive diversity toggles antenna every 60 ms while waiting.
// - Toggling stops after two preamble symbols.
// - Software then swaps and resumes if weak, or lets reception go on.
// - Antenna select drives out, with its complement on a second output.
// - In BLE mode software picks the antenna on the same outputs.
// - BLE may follow the antenna chosen by the 802.15.4 diversity logic.
// - Front-end outputs mark transmit state and receive state.
module bb_ieee802154_baseband import bb_pkg::*; #(
    parameter int AW          = 12,
    parameter int CW          = 24,
    parameter int BACKOFF_P   = BACKOFF_CYC,
    parameter int ACKWAIT_P   = ACKWAIT_CYC,
    parameter int TURN_P      = TURN_CYC,
    parameter int DIV_P       = DIV_CYC
) (
    // Clock and reset
    input  wire logic          i_core_clk,
    input  wire logic          i_sys_rst,
    // Software parameters and controls
    input  wire logic          i_timer_hit,
    input  wire logic [AW-1:0] i_tx_base,
    input  wire logic [7:0]    i_tx_len,
    input  wire logic [15:0]   i_tx_fc,
    input  wire logic [7:0]    i_tx_seq,
    input  wire logic [15:0]   i_tx_dst,
    input  wire logic [2:0]    i_tx_retries,
    input  wire logic          i_tx_div_en,
    input  wire logic [AW-1:0] i_rx_base,
    input  wire logic          i_rx_en,
    input  wire logic          i_auto_ack_en,
    input  wire logic          i_rx_div_en,
    input  wire logic          i_sw_weak,
    input  wire logic          i_ble_mode,
    input  wire logic          i_ble_ant,
    input  wire logic          i_ble_use_154,
    // RAM ports
    output logic [AW-1:0]      o_ram_raddr,
    input  wire logic [7:0]    i_ram_rdata,
    output logic               o_ram_we,
    output logic [AW-1:0]      o_ram_waddr,
    output logic [7:0]         o_ram_wdata,
    // Modem
    output logic [7:0]         o_mod_tx_byte,
    output logic               o_mod_tx_valid,
    input  wire logic          i_mod_tx_ready,
    output logic               o_cca_req,
    input  wire logic          i_cca_done,
    input  wire logic          i_cca_clear,
    input  wire logic          i_rx_start,
    input  wire logic          i_rx_valid,
    input  wire logic [7:0]    i_rx_byte,
    input  wire logic [7:0]    i_lqi,
    input  wire logic          i_preamble_sym,
    // Status to software
    output logic               o_rx_irq,
    output logic               o_ack_irq,
    output logic               o_tx_done,
    output logic               o_tx_fail,
    output logic               o_rx_crc_ok,
    output logic [7:0]         o_rx_lqi,
    output logic               o_div_hold,
    // Antenna and front end
    output logic               o_antenna_select_out,
    output logic               o_antenna_select_complement,
    output logic               o_tx_state_indicator,
    output logic               o_rx_state_indicator
);
    // Elaboration checks
    if (AW < 8 || CW < 16 || $clog2(DIV_P + 1) > CW || $clog2(ACKWAIT_P + 1) > CW
        || BACKOFF_P < 1 || TURN_P < 1 || DIV_P < 2)
        $error("bb_ieee802154_baseband: parameter out of range");

    typedef struct packed {
        bb_st_type       st;
        logic [CW-1:0]   cnt;
        logic [CW-1:0]   dcnt;
        logic [2:0]      nb;
        logic [2:0]      be;
        logic [2:0]      retry;
        logic [15:0]     lfsr;
        logic [15:0]     crc;
        logic [7:0]      idx;
        logic [7:0]      len;
        logic [7:0]      seq;
        logic [7:0]      rfc;
        logic [7:0]      rseq;
        logic [7:0]      byte_q;
        logic [7:0]      lqi;
        logic [7:0]      wdata;
        logic [1:0]      pre;
        logic [AW-1:0]   raddr;
        logic [AW-1:0]   waddr;
        logic            fetched;
        logic            txv;
        logic            is_ack;
        logic            want_ack;
        logic            we;
        logic            rx_irq;
        logic            ack_irq;
        logic            tx_done;
        logic            tx_fail;
        logic            crc_ok;
        logic            cca_req;
        logic            hold;
        logic            ant;
        logic            ant_o;
        logic            ant_n;
        logic            tx_ind;
        logic            rx_ind;
    } bb_state_type;

    bb_state_type r;
    bb_state_type n;
    logic         div_wait;

    // Random backoff length in cycles for a given exponent
    function automatic logic [CW-1:0] bo_len(input logic [2:0] be, input logic [15:0] rnd);
        logic [7:0] units;
        units = {3'h0, rnd[4:0]} & ((8'h01 << be) - 8'h01);
        return CW'(CW'(units) * CW'(BACKOFF_P));
    endfunction

    assign div_wait = i_rx_div_en && !i_ble_mode && r.st == S_IDLE && i_rx_en && !r.hold;

    // Next-state logic
    always_comb
    begin
        logic [7:0] hdr;
        logic [7:0] pay;
        logic [7:0] total;
        logic [7:0] b;
        logic       retry_go;
        logic       ok;
        n = r;
        hdr = r.is_ack ? ACK_HDR_LEN : HDR_LEN;
        pay = r.is_ack ? 8'h00 : i_tx_len;
        total = 8'(hdr + pay + CRC_LEN);
        b = 8'h00;
        retry_go = 1'b0;
        ok = 1'b0;
        n.we = 1'b0;
        n.rx_irq = 1'b0;
        n.ack_irq = 1'b0;
        n.tx_done = 1'b0;
        n.tx_fail = 1'b0;
        n.cca_req = 1'b0;
        n.lfsr = {r.lfsr[14:0], r.lfsr[15] ^ r.lfsr[13] ^ r.lfsr[12] ^ r.lfsr[10]};
        unique case (r.st)
            S_IDLE:
            begin
                if (i_timer_hit)
                begin
                    n.st = S_BO;
                    n.nb = 3'h0;
                    n.be = MIN_BE;
                    n.retry = 3'h0;
                    n.seq = i_tx_seq;
                    n.cnt = bo_len(MIN_BE, r.lfsr);
                end
                else if (i_rx_en && i_rx_start)
                begin
                    n.st = S_RX;
                    n.idx = 8'h00;
                    n.crc = 16'h0000;
                    n.want_ack = 1'b0;
                end
            end
            S_BO:
            begin
                if (r.cnt == '0)
                begin
                    n.st = S_CCA;
                    n.cca_req = 1'b1;
                end
                else
                    n.cnt = r.cnt - 1'b1;
            end
            S_CCA:
            begin
                if (i_cca_done && i_cca_clear)
                begin
                    n.st = S_TX;
                    n.idx = 8'h00;
                    n.crc = 16'h0000;
                    n.fetched = 1'b0;
                    n.is_ack = 1'b0;
                end
                else if (i_cca_done && r.nb == MAX_NB)
                begin
                    n.tx_fail = 1'b1;
                    n.st = S_IDLE;
                end
                else if (i_cca_done)
                begin
                    n.nb = r.nb + 3'h1;
                    n.be = (r.be == MAX_BE) ? r.be : r.be + 3'h1;
                    n.cnt = bo_len(n.be, r.lfsr);
                    n.st = S_BO;
                end
            end
            S_TX:
            begin
                if (r.txv)
                begin
                    if (i_mod_tx_ready)
                    begin
                        n.txv = 1'b0;
                        n.idx = r.idx + 8'h01;
                        if (r.idx == total - 8'h01)
                        begin
                            if (r.is_ack)
                            begin
                                n.ack_irq = 1'b1;
                                n.st = S_IDLE;
                            end
                            else if (i_tx_fc[FC_AR_BIT])
                            begin
                                n.st = S_ACKW;
                                n.cnt = CW'(ACKWAIT_P);
                            end
                            else
                            begin
                                n.tx_done = 1'b1;
                                n.st = S_IDLE;
                            end
                        end
                    end
                end
                else if (r.idx >= hdr && r.idx < hdr + pay && !r.fetched)
                begin
                    n.raddr = i_tx_base + AW'(r.idx - hdr);
                    n.fetched = 1'b1;
                end
                else
                begin
                    // Length, header, payload as stored, then CRC low and high
                    if (r.idx == 8'h00)
                        b = total - 8'h01;
                    else if (r.idx == total - 8'h02)
                        b = r.crc[7:0];
                    else if (r.idx == total - 8'h01)
                        b = r.crc[15:8];
                    else if (r.idx >= hdr)
                        b = i_ram_rdata;
                    else if (r.is_ack)
                        b = (r.idx == 8'h01) ? ACK_FC_LO : (r.idx == 8'h03) ? r.rseq : 8'h00;
                    else
                        unique case (r.idx)
                            8'h01: b = i_tx_fc[7:0];
                            8'h02: b = i_tx_fc[15:8];
                            8'h03: b = r.seq;
                            8'h04: b = i_tx_dst[7:0];
                            default: b = i_tx_dst[15:8];
                        endcase
                    n.byte_q = b;
                    n.txv = 1'b1;
                    n.fetched = 1'b0;
                    if (r.idx != 8'h00 && r.idx < total - 8'h02)
                        n.crc = crc_upd(r.crc, b);
                end
            end
            S_ACKW:
            begin
                if (i_rx_start)
                begin
                    n.st = S_RX;
                    n.idx = 8'h00;
                    n.crc = 16'h0000;
                    n.want_ack = 1'b1;
                end
                else if (r.cnt == '0)
                    retry_go = 1'b1;
                else
                    n.cnt = r.cnt - 1'b1;
            end
            S_RX:
            begin
                if (i_rx_valid)
                begin
                    n.we = 1'b1;
                    n.waddr = i_rx_base + AW'(r.idx);
                    n.wdata = i_rx_byte;
                    n.idx = r.idx + 8'h01;
                    if (r.idx == 8'h00)
                        n.len = i_rx_byte;
                    else
                        n.crc = crc_upd(r.crc, i_rx_byte);
                    if (r.idx == 8'h01)
                        n.rfc = i_rx_byte;
                    if (r.idx == 8'h03)
                        n.rseq = i_rx_byte;
                    if (r.idx != 8'h00 && r.idx == r.len)
                    begin
                        ok = (n.crc == 16'h0000);
                        n.rx_irq = 1'b1;
                        n.crc_ok = ok;
                        n.lqi = i_lqi;
                        n.hold = 1'b0;
                        n.pre = 2'h0;
                        n.st = S_IDLE;
                        if (r.want_ack)
                        begin
                            if (ok && r.rfc[2:0] == FC_ACK_TYPE && n.rseq == r.seq)
                                n.tx_done = 1'b1;
                            else
                                retry_go = 1'b1;
                        end
                        else if (ok && r.rfc[FC_AR_BIT] && i_auto_ack_en
                                 && r.rfc[2:0] != FC_ACK_TYPE)
                        begin
                            n.st = S_TURN;
                            n.cnt = CW'(TURN_P);
                        end
                    end
                end
            end
            S_TURN:
            begin
                if (r.cnt == '0)
                begin
                    n.st = S_TX;
                    n.idx = 8'h00;
                    n.crc = 16'h0000;
                    n.fetched = 1'b0;
                    n.is_ack = 1'b1;
                end
                else
                    n.cnt = r.cnt - 1'b1;
            end
            default: n.st = S_IDLE;
        endcase
        // Retry after a missing or bad acknowledgement
        if (retry_go)
        begin
            if (r.retry == i_tx_retries)
            begin
                n.tx_fail = 1'b1;
                n.st = S_IDLE;
            end
            else
            begin
                n.retry = r.retry + 3'h1;
                n.ant = r.ant ^ i_tx_div_en;
                n.nb = 3'h0;
                n.be = MIN_BE;
                n.cnt = bo_len(MIN_BE, r.lfsr);
                n.st = S_BO;
            end
        end
        // Receive diversity timer and preamble stop
        if (div_wait)
        begin
            if (i_preamble_sym)
            begin
                n.pre = r.pre + 2'h1;
                if (n.pre == PRE_STOP)
                    n.hold = 1'b1;
            end
            if (r.dcnt == CW'(DIV_P - 1))
            begin
                n.dcnt = '0;
                n.ant = ~r.ant;
            end
            else
                n.dcnt = r.dcnt + 1'b1;
        end
        if (r.hold && i_sw_weak)
        begin
            n.hold = 1'b0;
            n.pre = 2'h0;
            n.ant = ~r.ant;
            n.dcnt = '0;
        end
        // Antenna pins, shared with BLE
        n.ant_o = (i_ble_mode && !i_ble_use_154) ? i_ble_ant : n.ant;
        n.ant_n = ~n.ant_o;
        n.tx_ind = (n.st == S_TX);
        n.rx_ind = (n.st == S_RX) || (n.st == S_ACKW) || (n.st == S_IDLE && i_rx_en);
    end

    // State register
    always_ff @(posedge i_core_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            r <= '{st: S_IDLE, lfsr: LFSR_SEED, ant_n: 1'b1, default: '0};
        else
            r <= n;
    end

    // Outputs straight from the state register
    assign o_ram_raddr = r.raddr;
    assign o_ram_we = r.we;
    assign o_ram_waddr = r.waddr;
    assign o_ram_wdata = r.wdata;
    assign o_mod_tx_byte = r.byte_q;
    assign o_mod_tx_valid = r.txv;
    assign o_cca_req = r.cca_req;
    assign o_rx_irq = r.rx_irq;
    assign o_ack_irq = r.ack_irq;
    assign o_tx_done = r.tx_done;
    assign o_tx_fail = r.tx_fail;
    assign o_rx_crc_ok = r.crc_ok;
    assign o_rx_lqi = r.lqi;
    assign o_div_hold = r.hold;
    assign o_antenna_select_out = r.ant_o;
    assign o_antenna_select_complement = r.ant_n;
    assign o_tx_state_indicator = r.tx_ind;
    assign o_rx_state_indicator = r.rx_ind;

    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    sequence s_turn_done;
        r.st == S_TURN && r.cnt == '0;
    endsequence

    a_timer_start: assert property (r.st == S_IDLE && i_timer_hit |=> r.st == S_BO)
        else $error("timer hit did not start backoff");
    a_csma_fail: assert property (r.st == S_CCA && i_cca_done && !i_cca_clear
        && r.nb == MAX_NB |=> o_tx_fail && r.st == S_IDLE)
        else $error("channel access did not give up");
    a_rx_write: assert property (r.st == S_RX && i_rx_valid
        |=> o_ram_we && o_ram_wdata == $past(i_rx_byte))
        else $error("received byte not written");
    a_rx_irq: assert property (o_rx_irq |-> $past(r.st) == S_RX ##1 !o_rx_irq)
        else $error("bad frame received pulse");
    a_ack_irq: assert property (o_ack_irq |-> $past(r.is_ack) && $past(r.st) == S_TX)
        else $error("ack pulse without ack transmit");
    a_ack_turn: assert property (s_turn_done |=> (r.st == S_TX && r.is_ack)
        ##1 o_mod_tx_valid)
        else $error("auto ack not started");
    a_div_toggle: assert property (div_wait && !r.hold && r.dcnt == CW'(DIV_P - 1)
        && !i_sw_weak |=> r.ant != $past(r.ant))
        else $error("antenna did not toggle");
    a_div_hold: assert property (r.hold && r.st == S_IDLE && !i_sw_weak
        |=> $stable(r.ant))
        else $error("antenna moved while held");
    a_ant_compl: assert property (o_antenna_select_complement == !o_antenna_select_out)
        else $error("antenna complement wrong");
    a_tx_ind: assert property (o_tx_state_indicator |-> r.st == S_TX && !o_rx_state_indicator)
        else $error("front end indicators wrong");
endmodule

// ==== tb/bb_modem_model.sv ====
// Modem and RAM stand-in: byte sink with optional stall, CCA answer, RAM.
// Assumes the bench preloads mem and reads the sent queue.
`timescale 1ns/1ps
module bb_modem_model (
    // Clock
    input  wire logic        i_core_clk,
    // RAM side
    input  wire logic [11:0] i_raddr,
    output logic [7:0]       o_rdata,
    // Modem side
    input  wire logic        i_valid,
    input  wire logic [7:0]  i_byte,
    output logic             o_ready,
    input  wire logic        i_cca_req,
    output logic             o_cca_done,
    output logic             o_cca_clear,
    // Behaviour selection
    input  wire logic        i_busy,
    input  wire logic        i_slow
);
    logic [7:0] mem [0:4095];
    logic [7:0] sent [$];
    logic [1:0] stall_r = 2'h0;
    // Quiet start
    initial
    begin
        o_ready = 1'b0;
        o_cca_done = 1'b0;
        o_cca_clear = 1'b0;
    end
    // RAM read, data follows the address
    assign o_rdata = mem[i_raddr];
    // Modem byte sink with optional stall
    always @(posedge i_core_clk)
    begin
        stall_r <= stall_r + 2'h1;
        o_ready <= !i_slow || stall_r[1];
        if (i_valid && o_ready)
            sent.push_back(i_byte);
    end
    // Channel verdict one cycle after each request; wanders otherwise
    always @(posedge i_core_clk)
    begin
        o_cca_done <= i_cca_req;
        o_cca_clear <= i_cca_req ? !i_busy : !o_cca_clear;
    end
endmodule

// ==== tb/bb_ieee802154_baseband_test.sv ====
// Bench for the baseband: modem/RAM model, reference frames from queues.
// Assumes shortened timing parameters given at the instance.
`timescale 1ns/1ps
module bb_ieee802154_baseband_test;
    logic i_core_clk, i_sys_rst, i_timer_hit, i_tx_div_en, i_rx_en, i_auto_ack_en, a;
    logic i_rx_div_en, i_sw_weak, i_ble_mode, i_ble_ant, i_ble_use_154, i_mod_tx_ready;
    logic i_cca_done, i_cca_clear, i_rx_start, i_rx_valid, i_preamble_sym, busy, slow;
    logic [11:0] i_tx_base, i_rx_base, o_ram_raddr, o_ram_waddr;
    logic [15:0] i_tx_fc, i_tx_dst;
    logic [7:0] i_tx_len, i_tx_seq, i_ram_rdata, o_ram_wdata, o_mod_tx_byte, i_rx_byte;
    logic [7:0] i_lqi, o_rx_lqi;
    logic [2:0] i_tx_retries;
    logic o_ram_we, o_mod_tx_valid, o_cca_req, o_rx_irq, o_ack_irq, o_tx_done, o_tx_fail;
    logic o_rx_crc_ok, o_div_hold, o_antenna_select_out, o_antenna_select_complement;
    logic o_tx_state_indicator, o_rx_state_indicator;
    int n_fail = 0, num_checks = 0, cyc = 0, seed = 71386, n_rx, n_ack, n_done, n_txf, n_cca, tog;
    logic [7:0] q [$], e [$];
    logic [19:0] wq [$];
    bb_ieee802154_baseband #(.AW(12), .BACKOFF_P(4), .ACKWAIT_P(50), .TURN_P(3), .DIV_P(20))
    i_bb_ieee802154_baseband (.i_core_clk, .i_sys_rst, .i_timer_hit, .i_tx_base, .i_tx_len,
        .i_tx_fc, .i_tx_seq, .i_tx_dst, .i_tx_retries, .i_tx_div_en, .i_rx_base, .i_rx_en,
        .i_auto_ack_en, .i_rx_div_en, .i_sw_weak, .i_ble_mode, .i_ble_ant, .i_ble_use_154,
        .o_ram_raddr, .i_ram_rdata, .o_ram_we, .o_ram_waddr, .o_ram_wdata, .o_mod_tx_byte,
        .o_mod_tx_valid, .i_mod_tx_ready, .o_cca_req, .i_cca_done, .i_cca_clear, .i_rx_start,
        .i_rx_valid, .i_rx_byte, .i_lqi, .i_preamble_sym, .o_rx_irq, .o_ack_irq, .o_tx_done,
        .o_tx_fail, .o_rx_crc_ok, .o_rx_lqi, .o_div_hold, .o_antenna_select_out,
        .o_antenna_select_complement, .o_tx_state_indicator, .o_rx_state_indicator);
    bb_modem_model i_bb_modem_model (.i_core_clk, .i_raddr(o_ram_raddr), .o_rdata(i_ram_rdata),
        .i_valid(o_mod_tx_valid), .i_byte(o_mod_tx_byte), .o_ready(i_mod_tx_ready),
        .i_cca_req(o_cca_req), .o_cca_done(i_cca_done), .o_cca_clear(i_cca_clear),
        .i_busy(busy), .i_slow(slow));
    // Clock
    initial
    begin
        i_core_clk = 1'b0;
        forever #20 i_core_clk = ~i_core_clk;
    end
    // Compare and count
    task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Reference reflected CRC-16, low bit first
    function automatic logic [15:0] crc_of(input logic [7:0] d [$]);
        logic [15:0] c;
        c = 16'h0000;
        foreach (d[i])
            for (int k = 0; k < 8; k++)
                c = (c[0] ^ d[i][k]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
        return c;
    endfunction
    task automatic pulse(ref logic s);
        @(negedge i_core_clk);
        s = 1'b1;
        @(negedge i_core_clk);
        s = 1'b0;
    endtask
    // Pulse counts, RAM writes, per-cycle output relations, timeout
    always @(negedge i_core_clk)
    begin
        cyc++;
        if (o_ram_we)
            wq.push_back({o_ram_waddr, o_ram_wdata});
        n_rx += o_rx_irq;
        n_ack += o_ack_irq;
        n_done += o_tx_done;
        n_txf += o_tx_fail;
        n_cca += o_cca_req;
        if (cyc > 14)
            chk(o_antenna_select_complement, !o_antenna_select_out);
        if (o_mod_tx_valid)
            chk(o_tx_state_indicator, 1'b1);
        if (cyc == 20000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end
    // Scheduled transmit and reference frame
    task automatic tx_run(input logic [7:0] len, input logic [15:0] fc, input logic [2:0] rt);
        logic [15:0] crc;
        @(negedge i_core_clk);
        {i_tx_len, i_tx_fc, i_tx_retries} = {len, fc, rt};
        {i_tx_seq, i_tx_dst} = 24'($random(seed));
        i_bb_modem_model.sent = {};
        {n_done, n_txf, n_cca} = 0;
        pulse(i_timer_hit);
        while (n_done + n_txf == 0)
            @(negedge i_core_clk);
        q = {fc[7:0], fc[15:8], i_tx_seq, i_tx_dst[7:0], i_tx_dst[15:8]};
        for (int i = 0; i < len; i++)
            q.push_back(i_bb_modem_model.mem[i_tx_base + 12'(i)]);
        crc = crc_of(q);
        e = {len + 8'h07, q, crc[7:0], crc[15:8]};
        if (!busy)
        begin
            chk(i_bb_modem_model.sent.size(), e.size() * (rt + 1));
            foreach (e[i])
                chk(i_bb_modem_model.sent[i], e[i]);
        end
    endtask
    // Receive one frame asking for acknowledgement, good or corrupted
    task automatic rx_run(input logic bad);
        logic [15:0] crc;
        q = {8'h21, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 2; i < 7; i++)
            q[i] = 8'($random(seed));
        crc = crc_of(q);
        e = {8'h09, q, crc[7:0] ^ {7'h00, bad}, crc[15:8]};
        wq = {};
        i_bb_modem_model.sent = {};
        {n_rx, n_ack} = 0;
        i_lqi = 8'($random(seed));
        pulse(i_rx_start);
        foreach (e[i])
        begin
            i_rx_valid = 1'b1;
            i_rx_byte = e[i];
            chk(o_rx_state_indicator, 1'b1);
            @(negedge i_core_clk);
        end
        i_rx_valid = 1'b0;
        repeat (3) @(negedge i_core_clk);
        chk(n_rx, 1);
        chk(o_rx_crc_ok, !bad);
        chk(o_rx_lqi, i_lqi);
        foreach (e[i])
            chk(wq[i], {i_rx_base + 12'(i), e[i]});
        repeat (60) @(negedge i_core_clk);
        chk(n_ack, !bad);
        if (!bad)
            chk({i_bb_modem_model.sent[1], i_bb_modem_model.sent[2], i_bb_modem_model.sent[3]},
                {8'h02, 8'h00, e[3]});
    endtask
    // Main sequence
    initial
    begin
        {i_sys_rst, i_timer_hit, i_tx_div_en, i_rx_en, i_auto_ack_en, i_rx_div_en} = 6'h20;
        {i_sw_weak, i_ble_mode, i_ble_ant, i_ble_use_154, i_rx_start, i_rx_valid} = 6'h00;
        {i_preamble_sym, busy, slow, i_rx_byte, i_lqi} = 19'h00000;
        {i_tx_base, i_rx_base, i_tx_fc, i_tx_dst, i_tx_len, i_tx_seq} = {12'h100, 12'h200, 48'h0};
        i_tx_retries = 3'h0;
        for (int i = 0; i < 256; i++)
            i_bb_modem_model.mem[12'h100 + 12'(i)] = 8'($random(seed));
        repeat (12) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        {i_rx_en, i_auto_ack_en} = 2'h3;
        slow = 1'b1;
        tx_run(8'h01 + 8'($random(seed) & 7), 16'h0001, 3'h0);
        chk(n_done, 1);
        busy = 1'b1;
        tx_run(8'h03, 16'h0001, 3'h0);
        chk({n_txf[7:0], n_cca[7:0]}, 16'h0105);
        {busy, slow, i_tx_div_en} = 3'h1;
        a = o_antenna_select_out;
        tx_run(8'h02, 16'h0021, 3'h1);
        chk({n_done[7:0], n_txf[7:0]}, 16'h0001);
        chk(o_antenna_select_out, !a);
        rx_run(1'b0);
        rx_run(1'b1);
        i_rx_div_en = 1'b1;
        tog = 0;
        repeat (100)
        begin
            a = o_antenna_select_out;
            @(negedge i_core_clk);
            tog += (o_antenna_select_out != a);
        end
        chk(tog, 5);
        pulse(i_preamble_sym);
        pulse(i_preamble_sym);
        a = o_antenna_select_out;
        repeat (60) @(negedge i_core_clk);
        chk({o_div_hold, o_antenna_select_out}, {1'b1, a});
        pulse(i_sw_weak);
        repeat (2) @(negedge i_core_clk);
        chk({o_div_hold, o_antenna_select_out}, {1'b0, !a});
        i_rx_div_en = 1'b0;
        repeat (2) @(negedge i_core_clk);
        a = o_antenna_select_out;
        {i_ble_mode, i_ble_ant} = {1'b1, !a};
        repeat (2) @(negedge i_core_clk);
        chk(o_antenna_select_out, !a);
        i_ble_use_154 = 1'b1;
        repeat (2) @(negedge i_core_clk);
        chk(o_antenna_select_out, a);
        tally_and_finish();
    end
endmodule
